// file: sbirq_top.sv
// Interrupt event collection, masking and iso transmit context control
`timescale 1ns/1ns
`default_nettype none
module sbirq_top import sbirq_pkg::*; #(
  parameter int NCTX = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [10:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic at_req_done,
  input wire logic at_resp_done,
  input wire logic [1:0] at_irq_field,
  input wire logic [4:0] at_ack_code,
  input wire logic ar_req_packet,
  input wire logic ar_resp_packet,
  input wire logic ar_req_buf_done,
  input wire logic ar_resp_buf_done,
  input wire logic [1:0] ar_irq_field,
  input wire logic [31:0] misc_event,
  input wire logic [NCTX-1:0] it_ctx_irq,
  input wire logic [NCTX-1:0] ir_ctx_irq,
  input wire logic [NCTX-1:0] it_ctx_halted,
  input wire logic [NCTX-1:0] it_ctx_dead,
  output logic host_irq,
  output logic cycle_mismatch_flag,
  output logic [NCTX-1:0] it_ctx_run,
  output logic [NCTX-1:0] it_ctx_active,
  output logic [NCTX-1:0] it_ctx_wake,
  output logic [NCTX*32-1:0] it_ctx_dptr
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [31:0] global_event_flags;
  logic [31:0] global_event_enables;
  logic [31:0] iso_transmit_context_events;
  logic [31:0] iso_transmit_context_enables;
  logic [31:0] iso_receive_context_events;
  logic [31:0] iso_receive_context_enables;
  logic [31:0] evt_hw;
  logic [31:0] itevt_hw;
  logic [31:0] irevt_hw;
  logic event_clear_port;
  logic ctx_hit;
  logic [2:0] ctx_sel;
  logic [1:0] ctx_word;
  logic global_irq_gate;

  function automatic logic wr_at(input logic [10:0] a);
    wr_at = reg_wr_en && (reg_addr == a);
  endfunction

  assign event_clear_port = wr_at(SBIRQ_EVT_CLR);
  assign ctx_hit = (reg_addr[10:7] == SBIRQ_ITCTX_BASE[10:7]) && (reg_addr[1:0] == 2'h0);
  assign ctx_sel = reg_addr[6:4];
  assign ctx_word = reg_addr[3:2];

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  always_comb begin
    evt_hw = misc_event & SBIRQ_MISC_IMPL;
    evt_hw[SBIRQ_B_REQ_TX] = at_req_done && sbirq_tx_hit(at_irq_field, at_ack_code);
    evt_hw[SBIRQ_B_RESP_TX] = at_resp_done && sbirq_tx_hit(at_irq_field, at_ack_code);
    evt_hw[SBIRQ_B_REQ_BUF] = ar_req_buf_done && (ar_irq_field == SBIRQ_I_ALWAYS);
    evt_hw[SBIRQ_B_RESP_BUF] = ar_resp_buf_done && (ar_irq_field == SBIRQ_I_ALWAYS);
    evt_hw[SBIRQ_B_REQ_PKT] = ar_req_packet;
    evt_hw[SBIRQ_B_RESP_PKT] = ar_resp_packet;
    evt_hw[SBIRQ_B_ISO_TX] = |(it_ctx_irq & iso_transmit_context_enables[NCTX-1:0]);
    evt_hw[SBIRQ_B_ISO_RX] = |(ir_ctx_irq & iso_receive_context_enables[NCTX-1:0]);
    itevt_hw = '0;
    irevt_hw = '0;
    itevt_hw[NCTX-1:0] = it_ctx_irq;
    irevt_hw[NCTX-1:0] = ir_ctx_irq;
  end

  // ----------------------------------------
  // Event and enable registers
  // ----------------------------------------
  sbirq_setclr #(.W(32), .IMPL(SBIRQ_EVT_IMPL)) u_evt (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_EVT_SET)), .clr_wr(event_clear_port),
    .wdata(reg_wdata), .hw_set(evt_hw), .value(global_event_flags));
  sbirq_setclr #(.W(32), .IMPL(SBIRQ_EN_IMPL)) u_en (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_EN_SET)), .clr_wr(wr_at(SBIRQ_EN_CLR)),
    .wdata(reg_wdata), .hw_set(32'h0000_0000), .value(global_event_enables));
  sbirq_setclr #(.W(32), .IMPL(32'(2**NCTX - 1))) u_itevt (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_ITEVT_SET)), .clr_wr(wr_at(SBIRQ_ITEVT_CLR)),
    .wdata(reg_wdata), .hw_set(itevt_hw), .value(iso_transmit_context_events));
  sbirq_setclr #(.W(32), .IMPL(32'(2**NCTX - 1))) u_iten (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_ITEN_SET)), .clr_wr(wr_at(SBIRQ_ITEN_CLR)),
    .wdata(reg_wdata), .hw_set(32'h0000_0000), .value(iso_transmit_context_enables));
  sbirq_setclr #(.W(32), .IMPL(32'(2**NCTX - 1))) u_irevt (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_IREVT_SET)), .clr_wr(wr_at(SBIRQ_IREVT_CLR)),
    .wdata(reg_wdata), .hw_set(irevt_hw), .value(iso_receive_context_events));
  sbirq_setclr #(.W(32), .IMPL(32'(2**NCTX - 1))) u_iren (
    .core_clk(core_clk), .reset(reset), .set_wr(wr_at(SBIRQ_IREN_SET)), .clr_wr(wr_at(SBIRQ_IREN_CLR)),
    .wdata(reg_wdata), .hw_set(32'h0000_0000), .value(iso_receive_context_enables));

  // ----------------------------------------
  // Host interrupt line
  // ----------------------------------------
  assign global_irq_gate = global_event_enables[SBIRQ_B_MASTER];
  assign host_irq = global_irq_gate && |(global_event_flags[30:0] & global_event_enables[30:0]);
  assign cycle_mismatch_flag = global_event_flags[SBIRQ_B_MISMATCH];

  // ----------------------------------------
  // Iso transmit context control
  // ----------------------------------------
  logic [NCTX-1:0] cycle_match_gate;
  logic [14:0] ctx_match [NCTX];
  logic [31:0] descriptor_pointer [NCTX];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cycle_match_gate <= '0;
      it_ctx_run <= '0;
      it_ctx_wake <= '0;
      for (int n = 0; n < NCTX; n++) begin
        ctx_match[n] <= '0;
      end
    end else begin
      it_ctx_wake <= '0;
      if (reg_wr_en && ctx_hit && (ctx_word == SBIRQ_CTX_SET)) begin
        cycle_match_gate[ctx_sel] <= cycle_match_gate[ctx_sel] | reg_wdata[SBIRQ_C_GATE];
        ctx_match[ctx_sel] <= ctx_match[ctx_sel] | reg_wdata[SBIRQ_C_MATCH_HI:SBIRQ_C_MATCH_LO];
        it_ctx_run[ctx_sel] <= it_ctx_run[ctx_sel] | reg_wdata[SBIRQ_C_RUN];
        it_ctx_wake[ctx_sel] <= reg_wdata[SBIRQ_C_WAKE];
      end else if (reg_wr_en && ctx_hit && (ctx_word == SBIRQ_CTX_CLR)) begin
        cycle_match_gate[ctx_sel] <= cycle_match_gate[ctx_sel] & ~reg_wdata[SBIRQ_C_GATE];
        ctx_match[ctx_sel] <= ctx_match[ctx_sel] & ~reg_wdata[SBIRQ_C_MATCH_HI:SBIRQ_C_MATCH_LO];
        it_ctx_run[ctx_sel] <= it_ctx_run[ctx_sel] & ~reg_wdata[SBIRQ_C_RUN];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int n = 0; n < NCTX; n++) begin
        descriptor_pointer[n] <= SBIRQ_RESET_VAL;
      end
    end else if (reg_wr_en && ctx_hit && (ctx_word == SBIRQ_CTX_PTR)) begin
      descriptor_pointer[ctx_sel] <= reg_wdata;
    end
  end

  // Cycle matched contexts held inactive while the mismatch flag stands
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      it_ctx_active <= '0;
    end else begin
      for (int n = 0; n < NCTX; n++) begin
        if (it_ctx_run[n] && cycle_match_gate[n] && cycle_mismatch_flag) begin
          it_ctx_active[n] <= 1'b0;
        end else if (it_ctx_run[n]) begin
          it_ctx_active[n] <= 1'b1;
        end else if (it_ctx_halted[n]) begin
          it_ctx_active[n] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NCTX; n++) begin
      it_ctx_dptr[n*32 +: 32] = descriptor_pointer[n];
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ctx_hit && (ctx_word == SBIRQ_CTX_PTR)) begin
      next_rdata = descriptor_pointer[ctx_sel];
    end else if (ctx_hit && (ctx_word != 2'h2)) begin
      next_rdata[SBIRQ_C_GATE] = cycle_match_gate[ctx_sel];
      next_rdata[SBIRQ_C_MATCH_HI:SBIRQ_C_MATCH_LO] = ctx_match[ctx_sel];
      next_rdata[SBIRQ_C_RUN] = it_ctx_run[ctx_sel];
      next_rdata[SBIRQ_C_DEAD] = it_ctx_dead[ctx_sel];
      next_rdata[SBIRQ_C_ACTIVE] = it_ctx_active[ctx_sel];
    end else begin
      unique case (reg_addr)
        SBIRQ_EVT_SET, SBIRQ_EVT_CLR: next_rdata = global_event_flags;
        SBIRQ_EN_SET, SBIRQ_EN_CLR: next_rdata = global_event_enables;
        SBIRQ_ITEVT_SET, SBIRQ_ITEVT_CLR: next_rdata = iso_transmit_context_events;
        SBIRQ_ITEN_SET, SBIRQ_ITEN_CLR: next_rdata = iso_transmit_context_enables;
        SBIRQ_IREVT_SET, SBIRQ_IREVT_CLR: next_rdata = iso_receive_context_events;
        SBIRQ_IREN_SET, SBIRQ_IREN_CLR: next_rdata = iso_receive_context_enables;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_IRQ_NEEDS_GATE: assert property (@(posedge core_clk) disable iff (reset)
    host_irq |-> global_event_enables[SBIRQ_B_MASTER] && (global_event_flags[30:0] != 31'h0000_0000))
    else $error("Interrupt without master gate or flag");
  AST_TX_ALWAYS: assert property (@(posedge core_clk) disable iff (reset)
    at_req_done && (at_irq_field == SBIRQ_I_ALWAYS) |=> global_event_flags[SBIRQ_B_REQ_TX])
    else $error("Request transmit done not flagged");
  AST_TX_ACK_OK: assert property (@(posedge core_clk) disable iff (reset)
    at_resp_done && (at_irq_field == SBIRQ_I_ON_ERR) && (at_ack_code == SBIRQ_ACK_PENDING) &&
    !global_event_flags[SBIRQ_B_RESP_TX] && !reg_wr_en |=> !global_event_flags[SBIRQ_B_RESP_TX])
    else $error("Response done flagged on good ack");
  AST_PKT_ARRIVAL: assert property (@(posedge core_clk) disable iff (reset)
    ar_req_packet |=> global_event_flags[SBIRQ_B_REQ_PKT])
    else $error("Request packet arrival lost");
  AST_CTX_EVENT: assert property (@(posedge core_clk) disable iff (reset)
    it_ctx_irq != '0 |=> (iso_transmit_context_events[NCTX-1:0] & $past(it_ctx_irq)) == $past(it_ctx_irq))
    else $error("Transmit context event lost");
  AST_SUMMARY: assert property (@(posedge core_clk) disable iff (reset)
    (ir_ctx_irq & iso_receive_context_enables[NCTX-1:0]) != '0 |=> global_event_flags[SBIRQ_B_ISO_RX])
    else $error("Receive summary not set");
  AST_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    global_event_flags[SBIRQ_B_REQ_PKT] && !(event_clear_port && reg_wdata[SBIRQ_B_REQ_PKT])
    |=> global_event_flags[SBIRQ_B_REQ_PKT])
    else $error("Flag dropped without clear");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    event_clear_port && reg_wdata[SBIRQ_B_RESP_PKT] && !ar_resp_packet
    |=> !global_event_flags[SBIRQ_B_RESP_PKT])
    else $error("Clear write did not clear flag");
  AST_MASK_IMPL: assert property (@(posedge core_clk) disable iff (reset)
    wr_at(SBIRQ_ITEN_SET) && (reg_wdata == 32'hFFFF_FFFF)
    |=> iso_transmit_context_enables == 32'(2**NCTX - 1))
    else $error("Mask readback wrong width");
  AST_MATCH_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    it_ctx_run[0] && cycle_match_gate[0] && cycle_mismatch_flag |=> !it_ctx_active[0])
    else $error("Cycle matched context went active");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  AST_TX_ON_ERR: assert property (@(posedge core_clk) disable iff (reset)
    at_resp_done && (at_irq_field == SBIRQ_I_ON_ERR) && (at_ack_code != SBIRQ_ACK_COMPLETE) &&
    (at_ack_code != SBIRQ_ACK_PENDING) |=> global_event_flags[SBIRQ_B_RESP_TX])
    else $error("Response done not flagged on bad ack");
  AST_RESP_ARRIVAL: assert property (@(posedge core_clk) disable iff (reset)
    ar_resp_packet |=> global_event_flags[SBIRQ_B_RESP_PKT])
    else $error("Response packet arrival lost");
  AST_BUF_DONE: assert property (@(posedge core_clk) disable iff (reset)
    ar_req_buf_done && (ar_irq_field == SBIRQ_I_ALWAYS) |=> global_event_flags[SBIRQ_B_REQ_BUF])
    else $error("Request buffer done not flagged");
  AST_BUF_QUIET: assert property (@(posedge core_clk) disable iff (reset)
    ar_resp_buf_done && (ar_irq_field != SBIRQ_I_ALWAYS) && !global_event_flags[SBIRQ_B_RESP_BUF] &&
    !reg_wr_en |=> !global_event_flags[SBIRQ_B_RESP_BUF])
    else $error("Response buffer flagged without full field");
  AST_UNIT_EVENT: assert property (@(posedge core_clk) disable iff (reset)
    (misc_event & SBIRQ_MISC_IMPL) != 32'h0000_0000
    |=> (global_event_flags & $past(misc_event) & SBIRQ_MISC_IMPL) == ($past(misc_event) & SBIRQ_MISC_IMPL))
    else $error("Unit event lost");
  AST_TX_SUMMARY: assert property (@(posedge core_clk) disable iff (reset)
    (it_ctx_irq & iso_transmit_context_enables[NCTX-1:0]) != '0 |=> global_event_flags[SBIRQ_B_ISO_TX])
    else $error("Transmit summary not set");
  AST_SUMMARY_GATED: assert property (@(posedge core_clk) disable iff (reset)
    (ir_ctx_irq & iso_receive_context_enables[NCTX-1:0]) == '0 && !global_event_flags[SBIRQ_B_ISO_RX] &&
    !reg_wr_en |=> !global_event_flags[SBIRQ_B_ISO_RX])
    else $error("Masked receive context reached summary");
  AST_RX_CTX_EVENT: assert property (@(posedge core_clk) disable iff (reset)
    ir_ctx_irq != '0 |=> (iso_receive_context_events[NCTX-1:0] & $past(ir_ctx_irq)) == $past(ir_ctx_irq))
    else $error("Receive context event lost");
  AST_IRQ_RAISED: assert property (@(posedge core_clk) disable iff (reset)
    global_event_enables[SBIRQ_B_MASTER] &&
    ((global_event_flags[30:0] & global_event_enables[30:0]) != 31'h0000_0000) |-> host_irq)
    else $error("Enabled flag did not raise interrupt");
  AST_EN_SET: assert property (@(posedge core_clk) disable iff (reset)
    wr_at(SBIRQ_EN_SET)
    |=> (global_event_enables & $past(reg_wdata) & SBIRQ_EN_IMPL) == ($past(reg_wdata) & SBIRQ_EN_IMPL))
    else $error("Enable set write lost");
  AST_EN_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    wr_at(SBIRQ_EN_CLR) |=> (global_event_enables & $past(reg_wdata)) == 32'h0000_0000)
    else $error("Enable clear write did not clear");
  AST_RX_MASK_IMPL: assert property (@(posedge core_clk) disable iff (reset)
    wr_at(SBIRQ_IREN_SET) && (reg_wdata == 32'hFFFF_FFFF)
    |=> iso_receive_context_enables == 32'(2**NCTX - 1))
    else $error("Receive mask readback wrong width");
  AST_RUN_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr_en && ctx_hit && (ctx_word == SBIRQ_CTX_CLR) && (ctx_sel == 3'h0) && reg_wdata[SBIRQ_C_RUN]
    |=> !it_ctx_run[0])
    else $error("Run bit survived clear write");
  AST_ACTIVE_RUN: assert property (@(posedge core_clk) disable iff (reset)
    it_ctx_run[1] && !(cycle_match_gate[1] && cycle_mismatch_flag) |=> it_ctx_active[1])
    else $error("Running context not active");
endmodule
`default_nettype wire

// file: sbirq_pkg.sv
// Constants for the serial bus host interrupt aggregator
// Behaviour
// - DMA completion and unit events raise interrupt
// - Interrupt line from flags and enables only
// - Flags record events; enables select them
// - Event clear write clears selected flags not set by hardware that cycle
// - Request done bit 0, response bit 1
// - Transmit done on field 11b, or 01b+bad ack
// - Packet arrival flag per receive context
// - Buffer done flag when field equals 11b
// - Each of eight iso contexts per direction raises events
// - Iso context event reaches its summary flag gated by its mask bit
// - One summary flag per iso direction
// - Per context iso event bits 7..0
// - Mask readback shows only implemented contexts
// - Mismatch keeps cycle matched contexts inactive
// - Context control and descriptor pointer registers
`default_nettype none
package sbirq_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [10:0] SBIRQ_EVT_SET = 11'h080;
  localparam logic [10:0] SBIRQ_EVT_CLR = 11'h084;
  localparam logic [10:0] SBIRQ_EN_SET = 11'h088;
  localparam logic [10:0] SBIRQ_EN_CLR = 11'h08C;
  localparam logic [10:0] SBIRQ_ITEVT_SET = 11'h090;
  localparam logic [10:0] SBIRQ_ITEVT_CLR = 11'h094;
  localparam logic [10:0] SBIRQ_ITEN_SET = 11'h098;
  localparam logic [10:0] SBIRQ_ITEN_CLR = 11'h09C;
  localparam logic [10:0] SBIRQ_IREVT_SET = 11'h0A0;
  localparam logic [10:0] SBIRQ_IREVT_CLR = 11'h0A4;
  localparam logic [10:0] SBIRQ_IREN_SET = 11'h0A8;
  localparam logic [10:0] SBIRQ_IREN_CLR = 11'h0AC;
  // Transmit context block: base + 16*n, word 0 set, 1 clear, 3 pointer
  localparam logic [10:0] SBIRQ_ITCTX_BASE = 11'h200;
  localparam logic [1:0] SBIRQ_CTX_SET = 2'h0;
  localparam logic [1:0] SBIRQ_CTX_CLR = 2'h1;
  localparam logic [1:0] SBIRQ_CTX_PTR = 2'h3;
  // ----------------------------------------
  // Global event bit positions
  // ----------------------------------------
  localparam int SBIRQ_B_REQ_TX = 0;
  localparam int SBIRQ_B_RESP_TX = 1;
  localparam int SBIRQ_B_REQ_BUF = 2;
  localparam int SBIRQ_B_RESP_BUF = 3;
  localparam int SBIRQ_B_REQ_PKT = 4;
  localparam int SBIRQ_B_RESP_PKT = 5;
  localparam int SBIRQ_B_ISO_TX = 6;
  localparam int SBIRQ_B_ISO_RX = 7;
  localparam int SBIRQ_B_MISMATCH = 23;
  localparam int SBIRQ_B_MASTER = 31;
  // Implemented bits; unit events enter through the misc vector
  localparam logic [31:0] SBIRQ_EVT_IMPL = 32'h07FB_03FF;
  localparam logic [31:0] SBIRQ_EN_IMPL = 32'h87FB_03FF;
  localparam logic [31:0] SBIRQ_MISC_IMPL = 32'h07FB_0300;
  localparam logic [31:0] SBIRQ_RESET_VAL = 32'h0000_0000;
  // ----------------------------------------
  // Context control fields
  // ----------------------------------------
  localparam int SBIRQ_C_GATE = 31;
  localparam int SBIRQ_C_MATCH_HI = 30;
  localparam int SBIRQ_C_MATCH_LO = 16;
  localparam int SBIRQ_C_RUN = 15;
  localparam int SBIRQ_C_WAKE = 12;
  localparam int SBIRQ_C_DEAD = 11;
  localparam int SBIRQ_C_ACTIVE = 10;
  // ----------------------------------------
  // Descriptor interrupt field and ack codes
  // ----------------------------------------
  localparam logic [1:0] SBIRQ_I_ALWAYS = 2'h3;
  localparam logic [1:0] SBIRQ_I_ON_ERR = 2'h1;
  localparam logic [4:0] SBIRQ_ACK_COMPLETE = 5'h11;
  localparam logic [4:0] SBIRQ_ACK_PENDING = 5'h12;

  // Transmit done decision
  function automatic logic sbirq_tx_hit(input logic [1:0] field, input logic [4:0] ack);
    sbirq_tx_hit = (field == SBIRQ_I_ALWAYS) ||
                   ((field == SBIRQ_I_ON_ERR) && (ack != SBIRQ_ACK_COMPLETE) && (ack != SBIRQ_ACK_PENDING));
  endfunction
endpackage
`default_nettype wire

// file: sbirq_setclr.sv
// Set/clear register with hardware set inputs
`timescale 1ns/1ns
`default_nettype none
module sbirq_setclr import sbirq_pkg::*; #(
  parameter int W = 32,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic set_wr,
  input wire logic clr_wr,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] hw_set,
  output logic [W-1:0] value
);
  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      value <= '0;
    end else begin
      value <= ((value | (set_wr ? wdata : '0)) & ~(clr_wr ? wdata : '0) | hw_set) & IMPL;
    end
  end
endmodule
`default_nettype wire

// file: sbirq_tb.sv
// Self-checking testbench for the interrupt aggregator
`timescale 1ns/1ns
`default_nettype none
module testbench import sbirq_pkg::*;;
  logic core_clk, reset, reg_wr_en, reg_rd_en, reg_rd_valid, host_irq, cycle_mismatch_flag;
  logic at_req_done, at_resp_done, ar_req_packet, ar_resp_packet, ar_req_buf_done, ar_resp_buf_done;
  logic [10:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, misc_event;
  logic [1:0] at_irq_field, ar_irq_field;
  logic [4:0] at_ack_code;
  logic [7:0] it_ctx_irq, ir_ctx_irq, it_ctx_halted, it_ctx_dead, it_ctx_run, it_ctx_active, it_ctx_wake;
  logic [255:0] it_ctx_dptr;
  int num_errors, n_tests;

  sbirq_top #(.NCTX(8)) dut (.core_clk(core_clk), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .at_req_done(at_req_done), .at_resp_done(at_resp_done),
    .at_irq_field(at_irq_field), .at_ack_code(at_ack_code), .ar_req_packet(ar_req_packet),
    .ar_resp_packet(ar_resp_packet), .ar_req_buf_done(ar_req_buf_done),
    .ar_resp_buf_done(ar_resp_buf_done), .ar_irq_field(ar_irq_field), .misc_event(misc_event),
    .it_ctx_irq(it_ctx_irq), .ir_ctx_irq(ir_ctx_irq), .it_ctx_halted(it_ctx_halted),
    .it_ctx_dead(it_ctx_dead), .host_irq(host_irq), .cycle_mismatch_flag(cycle_mismatch_flag),
    .it_ctx_run(it_ctx_run), .it_ctx_active(it_ctx_active), .it_ctx_wake(it_ctx_wake),
    .it_ctx_dptr(it_ctx_dptr));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge core_clk);
    #10;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    tick();
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    int i;
    tick();
    reg_rd_en = 1'b1;
    reg_addr = a;
    tick();
    reg_rd_en = 1'b0;
    for (i = 0; i < 4 && reg_rd_valid !== 1'b1; i++) tick();
    if (reg_rd_valid !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t read strobe never answered", $time);
      wrap_up();
    end else begin
      chk(reg_rdata, exp);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(SBIRQ_EVT_SET, 32'h0000_0000);
    rd(SBIRQ_EN_SET, 32'h0000_0000);
    chk(32'(host_irq), 32'h0000_0000);
  endtask

  // Entries: hit flag, descriptor field, ack code
  task automatic t_async_tx();
    logic [7:0] tab [6] = '{8'hF1, 8'hA5, 8'h31, 8'h32, 8'h05, 8'h45};
    int i;
    logic e;
    for (i = 0; i < 6; i++) begin
      e = tab[i][7];
      tick();
      at_irq_field = tab[i][6:5];
      at_ack_code = tab[i][4:0];
      at_req_done = 1'b1;
      at_resp_done = 1'b1;
      tick();
      at_req_done = 1'b0;
      at_resp_done = 1'b0;
      rd(SBIRQ_EVT_SET, {30'h0, e, e});
      wr(SBIRQ_EVT_CLR, 32'h0000_0001);
      rd(SBIRQ_EVT_SET, {30'h0, e, 1'b0});
      wr(SBIRQ_EVT_CLR, 32'h0000_0002);
    end
  endtask

  task automatic t_async_rx();
    tick();
    ar_req_packet = 1'b1;
    ar_resp_packet = 1'b1;
    ar_irq_field = 2'h1;
    ar_req_buf_done = 1'b1;
    ar_resp_buf_done = 1'b1;
    tick();
    ar_req_packet = 1'b0;
    ar_resp_packet = 1'b0;
    ar_req_buf_done = 1'b0;
    ar_resp_buf_done = 1'b0;
    rd(SBIRQ_EVT_SET, 32'h0000_0030);
    ar_irq_field = 2'h3;
    ar_req_buf_done = 1'b1;
    ar_resp_buf_done = 1'b1;
    tick();
    ar_req_buf_done = 1'b0;
    ar_resp_buf_done = 1'b0;
    rd(SBIRQ_EVT_SET, 32'h0000_003C);
    wr(SBIRQ_EVT_CLR, 32'h0000_003C);
  endtask

  task automatic t_irq();
    tick();
    misc_event = 32'h0001_0000;
    tick();
    misc_event = 32'h0000_0000;
    rd(SBIRQ_EVT_SET, 32'h0001_0000);
    wr(SBIRQ_EN_SET, 32'h0001_0000);
    chk(32'(host_irq), 32'h0000_0000);
    wr(SBIRQ_EN_SET, 32'h8000_0000);
    chk(32'(host_irq), 32'h0000_0001);
    rd(SBIRQ_EN_CLR, 32'h8001_0000);
    wr(SBIRQ_EN_CLR, 32'h0001_0000);
    chk(32'(host_irq), 32'h0000_0000);
    wr(SBIRQ_EN_SET, 32'h0001_0000);
    wr(SBIRQ_EVT_CLR, 32'h0001_0000);
    chk(32'(host_irq), 32'h0000_0000);
  endtask

  // Direction 0 is transmit, 1 is receive
  task automatic t_iso();
    int d;
    logic [10:0] o;
    for (d = 0; d < 2; d++) begin
      o = 11'(d * 16);
      wr(SBIRQ_ITEN_SET + o, 32'hFFFF_FFFF);
      rd(SBIRQ_ITEN_SET + o, 32'h0000_00FF);
      wr(SBIRQ_ITEN_CLR + o, 32'h0000_00FE);
      tick();
      it_ctx_irq = (d == 0) ? 8'h80 : 8'h00;
      ir_ctx_irq = (d == 0) ? 8'h00 : 8'h80;
      tick();
      it_ctx_irq = 8'h00;
      ir_ctx_irq = 8'h00;
      rd(SBIRQ_ITEVT_SET + o, 32'h0000_0080);
      rd(SBIRQ_EVT_SET, 32'h0000_0000);
      tick();
      it_ctx_irq = (d == 0) ? 8'h01 : 8'h00;
      ir_ctx_irq = (d == 0) ? 8'h00 : 8'h01;
      tick();
      it_ctx_irq = 8'h00;
      ir_ctx_irq = 8'h00;
      rd(SBIRQ_ITEVT_SET + o, 32'h0000_0081);
      rd(SBIRQ_EVT_SET, 32'h0000_0040 << d);
      wr(SBIRQ_ITEVT_CLR + o, 32'h0000_0081);
      wr(SBIRQ_EVT_CLR, 32'h0000_00C0);
      rd(SBIRQ_ITEVT_SET + o, 32'h0000_0000);
    end
  endtask

  task automatic t_ctx();
    wr(SBIRQ_ITCTX_BASE + 11'h00C, 32'h1234_5670);
    chk(it_ctx_dptr[31:0], 32'h1234_5670);
    rd(SBIRQ_ITCTX_BASE + 11'h008, 32'h0000_0000);
    wr(SBIRQ_ITCTX_BASE, 32'h0000_1000);
    chk(32'(it_ctx_wake), 32'h0000_0001);
    wr(SBIRQ_EVT_SET, 32'h0080_0000);
    chk(32'(cycle_mismatch_flag), 32'h0000_0001);
    wr(SBIRQ_ITCTX_BASE, 32'h8000_8000);
    wr(SBIRQ_ITCTX_BASE + 11'h010, 32'h0000_8000);
    tick();
    tick();
    chk(32'(it_ctx_run[1:0]), 32'h0000_0003);
    chk(32'(it_ctx_active[1:0]), 32'h0000_0002);
    it_ctx_dead = 8'h01;
    rd(SBIRQ_ITCTX_BASE + 11'h004, 32'h8000_8800);
    it_ctx_dead = 8'h00;
    wr(SBIRQ_ITCTX_BASE + 11'h004, 32'h0000_8000);
    it_ctx_halted = 8'h01;
    tick();
    it_ctx_halted = 8'h00;
    wr(SBIRQ_EVT_CLR, 32'h0080_0000);
    chk(32'(cycle_mismatch_flag), 32'h0000_0000);
    repeat (2) tick();
    wr(SBIRQ_ITCTX_BASE, 32'h0000_8000);
    tick();
    tick();
    chk(32'(it_ctx_active[1:0]), 32'h0000_0003);
  endtask

  // ----------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    reset = 1'b1;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata, misc_event} = '0;
    {at_req_done, at_resp_done, at_irq_field, at_ack_code} = '0;
    {ar_req_packet, ar_resp_packet, ar_req_buf_done, ar_resp_buf_done, ar_irq_field} = '0;
    {it_ctx_irq, ir_ctx_irq, it_ctx_halted, it_ctx_dead} = '0;
    repeat (4) @(posedge core_clk);
    #10;
    reset = 1'b0;
    t_reset();
    t_async_tx();
    t_async_rx();
    t_irq();
    t_iso();
    t_ctx();
    wrap_up();
  end
endmodule
`default_nettype wire
